// File: rtl/rfpc_pkg.sv
// constants, types and decode functions of the receiver path control block
package rfpc_pkg;

  // ****************************************************
  // register indices (byte address is four times index)
  // ****************************************************
  localparam int unsigned IDX_W          = 4;
  localparam logic [3:0]  IDX_CHIP_STAT  = 4'h0;
  localparam logic [3:0]  IDX_PROTO      = 4'h1;
  localparam logic [3:0]  IDX_TUNE       = 4'hA;
  localparam logic [3:0]  IDX_LEVEL      = 4'hF;
  localparam int unsigned IDX_LSB        = 2;
  localparam int unsigned ADDR_MAP_MSB   = 5;
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;
  localparam logic [1:0]  HRESP_OKAY_W   = 2'h0;

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int unsigned CSC_MUX_SWAP   = 3;
  localparam int unsigned CSC_AGC_EN     = 2;
  localparam int unsigned TUNE_BP_110    = 7;
  localparam int unsigned TUNE_BP_200    = 6;
  localparam int unsigned TUNE_BP_450    = 5;
  localparam int unsigned TUNE_BP_100    = 4;
  localparam int unsigned TUNE_GR_MSB    = 3;
  localparam int unsigned TUNE_GR_LSB    = 2;
  localparam int unsigned TUNE_TRIG_X3   = 1;
  localparam int unsigned TUNE_ALWAYS_ON = 0;
  localparam int unsigned LVL_MSB        = 7;
  localparam int unsigned LVL_RSSI_LSB   = 5;
  localparam int unsigned PROTO_CLS_MSB  = 4;
  localparam int unsigned PROTO_CLS_LSB  = 3;

  // ****************************************************
  // reset values and presets
  // ****************************************************
  localparam logic [7:0]  CSC_RESET      = 8'h00;
  localparam logic [7:0]  PROTO_RESET    = 8'h00;
  localparam logic [7:0]  TUNE_RESET     = 8'h00;
  localparam logic [7:0]  PRESET_CLS0    = 8'h40;
  localparam logic [7:0]  PRESET_CLS1    = 8'h20;
  localparam logic [7:0]  PRESET_CLS2    = 8'h00;
  localparam logic [7:0]  PRESET_CLS3    = 8'h80;

  // ****************************************************
  // digitizer and gain control levels
  // ****************************************************
  localparam logic [7:0]  DIG_MIN_LEVEL  = 8'h10;
  localparam logic [7:0]  DIG_GR_STEP    = 8'h10;
  localparam logic [10:0] TRIG_MULT_X3   = 11'h003;
  localparam logic [10:0] TRIG_MULT_X5   = 11'h005;
  localparam logic [11:0] AGC_MARGIN     = 12'h008;
  localparam int unsigned FREEZE_EDGES   = 16;
  localparam int unsigned ATTEN_W        = 4;

  // ****************************************************
  // types
  // ****************************************************
  typedef enum logic [2:0] {
    BAND_240_1400 = 3'b000,
    BAND_110_570  = 3'b001,
    BAND_200_900  = 3'b010,
    BAND_450_1500 = 3'b011,
    BAND_100_1500 = 3'b100
  } rfpc_band_t;

  typedef enum logic [1:0] {
    AGC_IDLE   = 2'b00,
    AGC_TRACK  = 2'b01,
    AGC_FROZEN = 2'b10
  } rfpc_agc_state_t;

  // highest set passband bit wins
  function automatic rfpc_band_t rfpc_band_of(input logic [7:0] tune);
    if (tune[TUNE_BP_110]) begin
      return BAND_110_570;
    end else if (tune[TUNE_BP_200]) begin
      return BAND_200_900;
    end else if (tune[TUNE_BP_450]) begin
      return BAND_450_1500;
    end else if (tune[TUNE_BP_100]) begin
      return BAND_100_1500;
    end
    return BAND_240_1400;
  endfunction

  function automatic logic [7:0] rfpc_preset(input logic [7:0] proto);
    unique case (proto[PROTO_CLS_MSB:PROTO_CLS_LSB])
      2'b00: return PRESET_CLS0;
      2'b01: return PRESET_CLS1;
      2'b10: return PRESET_CLS2;
      2'b11: return PRESET_CLS3;
    endcase
  endfunction

endpackage

// File: rtl/rfpc_reg_if.sv
// register access carrier between bus slave and control core
`timescale 1ns/1ps
interface rfpc_reg_if;
  logic       wr_en;
  logic [3:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport slave (output wr_en, output idx, output wdata, input rdata);
  modport core (input wr_en, input idx, input wdata, output rdata);
endinterface

// File: rtl/rfpc_ahb_slave.sv
// ahb-lite slave: zero-wait writes, one-wait reads
`timescale 1ns/1ps
module rfpc_ahb_slave (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  rfpc_reg_if.slave        regs
);

  logic        dph_valid_reg, dph_valid_next;
  logic        dph_write_reg, dph_write_next;
  logic        dph_map_reg,   dph_map_next;
  logic [3:0]  dph_idx_reg,   dph_idx_next;
  logic [31:0] hrdata_reg,    hrdata_next;
  logic        hready_reg,    hready_next;
  logic        hresp_reg;
  logic        addr_ok;

  assign addr_ok = (haddr[31:rfpc_pkg::ADDR_MAP_MSB+1] == '0)
                   && (haddr[rfpc_pkg::IDX_LSB-1:0] == '0)
                   && (hsize == rfpc_pkg::HSIZE_WORD);

  always_comb begin
    dph_valid_next = dph_valid_reg;
    dph_write_next = dph_write_reg;
    dph_map_next   = dph_map_reg;
    dph_idx_next   = dph_idx_reg;
    hrdata_next    = hrdata_reg;
    hready_next    = hready_reg;
    if (dph_valid_reg && dph_write_reg) begin
      dph_valid_next = 1'b0;
    end
    if (dph_valid_reg && !dph_write_reg && !hready_reg) begin
      hrdata_next    = dph_map_reg ? {24'h00_0000, regs.rdata} : 32'h0000_0000;
      hready_next    = 1'b1;
      dph_valid_next = 1'b0;
    end
    if (hready && hsel && htrans[1]) begin
      dph_valid_next = 1'b1;
      dph_write_next = hwrite;
      dph_idx_next   = haddr[rfpc_pkg::ADDR_MAP_MSB:rfpc_pkg::IDX_LSB];
      dph_map_next   = addr_ok;
      hready_next    = hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_valid_reg <= 1'b0;
      dph_write_reg <= 1'b0;
      dph_map_reg   <= 1'b0;
      dph_idx_reg   <= rfpc_pkg::IDX_CHIP_STAT;
      hrdata_reg    <= 32'h0000_0000;
      hready_reg    <= 1'b1;
      hresp_reg     <= 1'b0;
    end else if (clk_en) begin
      dph_valid_reg <= dph_valid_next;
      dph_write_reg <= dph_write_next;
      dph_map_reg   <= dph_map_next;
      dph_idx_reg   <= dph_idx_next;
      hrdata_reg    <= hrdata_next;
      hready_reg    <= hready_next;
      hresp_reg     <= 1'b0;
    end
  end

  assign regs.wr_en = clk_en && dph_valid_reg && dph_write_reg && dph_map_reg;
  assign regs.idx   = dph_idx_reg;
  assign regs.wdata = hwdata[7:0];
  assign hrdata     = hrdata_reg;
  assign hreadyout  = hready_reg;
  assign hresp      = hresp_reg;

endmodule

// File: rtl/rfpc_agc.sv
// automatic gain control: peak-tracking attenuation with edge-count freeze
`timescale 1ns/1ps
module rfpc_agc #(
  parameter int unsigned FREEZE_EDGES = rfpc_pkg::FREEZE_EDGES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        agc_enable,
  input  wire logic        always_on,
  input  wire logic        rx_sof,
  input  wire logic        sub_edge,
  input  wire logic [7:0]  level,
  input  wire logic [10:0] threshold,
  output logic      [3:0]  atten,
  output logic             frozen
);

  rfpc_pkg::rfpc_agc_state_t state_reg, state_next;
  logic [4:0] cnt_reg,    cnt_next;
  logic [3:0] atten_reg,  atten_next;
  logic       frozen_reg, frozen_next;
  logic       over;

  assign over = {4'h0, level} > ({1'b0, threshold} + rfpc_pkg::AGC_MARGIN);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    atten_next = atten_reg;
    if (!agc_enable) begin
      state_next = rfpc_pkg::AGC_IDLE;
      atten_next = 4'h0;
      cnt_next   = 5'h00;
    end else if (rx_sof) begin
      state_next = rfpc_pkg::AGC_TRACK;
      atten_next = 4'h0;
      cnt_next   = 5'h00;
    end else begin
      unique case (state_reg)
        rfpc_pkg::AGC_IDLE: begin
          state_next = rfpc_pkg::AGC_TRACK;
        end
        rfpc_pkg::AGC_TRACK: begin
          if (over && atten_reg != 4'hF) begin
            atten_next = atten_reg + 4'h1;
          end
          if (sub_edge && !always_on) begin
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg == 5'(FREEZE_EDGES - 1)) begin
              state_next = rfpc_pkg::AGC_FROZEN;
            end
          end
        end
        rfpc_pkg::AGC_FROZEN: begin
          if (always_on) begin
            state_next = rfpc_pkg::AGC_TRACK;
          end
        end
        default: begin
          state_next = rfpc_pkg::AGC_IDLE;
        end
      endcase
    end
    frozen_next = (state_next == rfpc_pkg::AGC_FROZEN);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg  <= rfpc_pkg::AGC_IDLE;
      cnt_reg    <= 5'h00;
      atten_reg  <= 4'h0;
      frozen_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      atten_reg  <= atten_next;
      frozen_reg <= frozen_next;
    end
  end

  assign atten  = atten_reg;
  assign frozen = frozen_reg;

  a_agc_off_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && !agc_enable |=> atten == 4'h0 && !frozen)
    else $error("gain reduction active while control disabled");
  a_agc_only_up: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && agc_enable && !rx_sof |=> atten >= $past(atten))
    else $error("gain reduction decreased inside a reception");
  a_agc_sof_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && agc_enable && rx_sof |=> atten == 4'h0 && !frozen)
    else $error("gain reduction not cleared at start frame");
  a_agc_reacts: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && agc_enable && !rx_sof && state_reg == rfpc_pkg::AGC_TRACK && over
    && atten != 4'hF |=> atten == $past(atten) + 4'h1)
    else $error("gain reduction missed an over-threshold level");
  a_agc_freeze_16: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && agc_enable && !rx_sof && !always_on && state_reg == rfpc_pkg::AGC_TRACK
    && sub_edge && cnt_reg == 5'(FREEZE_EDGES - 1) |=> frozen)
    else $error("gain control not frozen after edge limit");
  a_agc_always_on: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && always_on |=> !frozen)
    else $error("gain control frozen in always-on mode");

endmodule

// File: rtl/rfpc_top.sv
// receiver path control: input routing, filter tuning, digitizer, gain control
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
module rfpc_top #(
  parameter int unsigned FREEZE_EDGES = rfpc_pkg::FREEZE_EDGES
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [7:0]  receive_input_one,
  input  wire logic [7:0]  receive_input_two,
  input  wire logic        tx_start,
  input  wire logic        rx_sof,
  output logic             main_subcarrier,
  output logic             mux_swap,
  output logic      [2:0]  band_sel,
  output logic             gain_cut_7db,
  output logic      [1:0]  dig_gain_red,
  output logic      [3:0]  agc_atten,
  output logic             agc_frozen
);

  // ****************************************************
  // register access
  // ****************************************************
  rfpc_reg_if regs ();

  rfpc_ahb_slave u_slave (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clk_en    (clk_en),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .regs      (regs)
  );

  logic [7:0] csc_reg,   csc_next;
  logic [7:0] proto_reg, proto_next;
  logic [7:0] tune_reg,  tune_next;
  logic       wr_csc, wr_proto, wr_tune;

  assign wr_csc   = regs.wr_en && regs.idx == rfpc_pkg::IDX_CHIP_STAT;
  assign wr_proto = regs.wr_en && regs.idx == rfpc_pkg::IDX_PROTO;
  assign wr_tune  = regs.wr_en && regs.idx == rfpc_pkg::IDX_TUNE;

  always_comb begin
    csc_next   = csc_reg;
    proto_next = proto_reg;
    tune_next  = tune_reg;
    if (wr_csc) begin
      csc_next = regs.wdata;
    end
    if (wr_proto) begin
      proto_next = regs.wdata;
      tune_next  = rfpc_pkg::rfpc_preset(regs.wdata);
    end
    if (wr_tune) begin
      tune_next = regs.wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      csc_reg   <= rfpc_pkg::CSC_RESET;
      proto_reg <= rfpc_pkg::PROTO_RESET;
      tune_reg  <= rfpc_pkg::TUNE_RESET;
    end else if (clk_en) begin
      csc_reg   <= csc_next;
      proto_reg <= proto_next;
      tune_reg  <= tune_next;
    end
  end

  // ****************************************************
  // input multiplexer and signal strength
  // ****************************************************
  logic [7:0] main_level, aux_level;
  logic [2:0] rssi_main_reg, rssi_main_next;
  logic [2:0] rssi_aux_reg,  rssi_aux_next;
  logic [2:0] main_peak, aux_peak;

  always_comb begin
    if (csc_reg[rfpc_pkg::CSC_MUX_SWAP]) begin
      main_level = receive_input_two;
      aux_level  = receive_input_one;
    end else begin
      main_level = receive_input_one;
      aux_level  = receive_input_two;
    end
  end

  assign main_peak = main_level[rfpc_pkg::LVL_MSB:rfpc_pkg::LVL_RSSI_LSB];
  assign aux_peak  = aux_level[rfpc_pkg::LVL_MSB:rfpc_pkg::LVL_RSSI_LSB];

  // peaks latch until the reader transmits again
  always_comb begin
    rssi_main_next = rssi_main_reg;
    rssi_aux_next  = rssi_aux_reg;
    if (tx_start) begin
      rssi_main_next = 3'h0;
      rssi_aux_next  = 3'h0;
    end else begin
      if (main_peak > rssi_main_reg) begin
        rssi_main_next = main_peak;
      end
      if (aux_peak > rssi_aux_reg) begin
        rssi_aux_next = aux_peak;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rssi_main_reg <= 3'h0;
      rssi_aux_reg  <= 3'h0;
    end else if (clk_en) begin
      rssi_main_reg <= rssi_main_next;
      rssi_aux_reg  <= rssi_aux_next;
    end
  end

  always_comb begin
    case (regs.idx)
      rfpc_pkg::IDX_CHIP_STAT: regs.rdata = csc_reg;
      rfpc_pkg::IDX_PROTO:     regs.rdata = proto_reg;
      rfpc_pkg::IDX_TUNE:      regs.rdata = tune_reg;
      rfpc_pkg::IDX_LEVEL:     regs.rdata = {2'b00, rssi_aux_reg, rssi_main_reg};
      default:                 regs.rdata = 8'h00;
    endcase
  end

  // ****************************************************
  // digitizer, filter selection and outputs
  // ****************************************************
  logic [1:0]  gr;
  logic [7:0]  win;
  logic [10:0] thr;
  logic        sub_next, sub_edge;
  logic        main_sub_reg;
  logic [2:0]  band_reg, band_next;
  logic        cut_reg, swap_reg;
  logic [1:0]  gr_reg;

  assign gr  = tune_reg[rfpc_pkg::TUNE_GR_MSB:rfpc_pkg::TUNE_GR_LSB];
  assign win = 8'(rfpc_pkg::DIG_MIN_LEVEL + {6'h00, gr} * rfpc_pkg::DIG_GR_STEP);
  assign thr = 11'({3'b000, win} * (tune_reg[rfpc_pkg::TUNE_TRIG_X3] ?
               rfpc_pkg::TRIG_MULT_X3 : rfpc_pkg::TRIG_MULT_X5));

  assign sub_next  = main_level > win;
  assign sub_edge  = sub_next != main_sub_reg;
  assign band_next = rfpc_pkg::rfpc_band_of(tune_reg);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_sub_reg <= 1'b0;
      band_reg     <= rfpc_pkg::BAND_240_1400;
      cut_reg      <= 1'b0;
      gr_reg       <= 2'b00;
      swap_reg     <= 1'b0;
    end else if (clk_en) begin
      main_sub_reg <= sub_next;
      band_reg     <= band_next;
      cut_reg      <= (band_next == rfpc_pkg::BAND_100_1500);
      gr_reg       <= gr;
      swap_reg     <= csc_reg[rfpc_pkg::CSC_MUX_SWAP];
    end
  end

  rfpc_agc #(
    .FREEZE_EDGES (FREEZE_EDGES)
  ) u_agc (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .clk_en     (clk_en),
    .agc_enable (csc_reg[rfpc_pkg::CSC_AGC_EN]),
    .always_on  (tune_reg[rfpc_pkg::TUNE_ALWAYS_ON]),
    .rx_sof     (rx_sof),
    .sub_edge   (sub_edge),
    .level      (main_level),
    .threshold  (thr),
    .atten      (agc_atten),
    .frozen     (agc_frozen)
  );

  assign main_subcarrier = main_sub_reg;
  assign mux_swap        = swap_reg;
  assign band_sel        = band_reg;
  assign gain_cut_7db    = cut_reg;
  assign dig_gain_red    = gr_reg;

  // ****************************************************
  // checks
  // ****************************************************
  a_mux_default: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && !csc_reg[rfpc_pkg::CSC_MUX_SWAP]
    |=> main_subcarrier == ($past(receive_input_one) > $past(win)))
    else $error("main path not fed from input one");
  a_mux_swapped: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && csc_reg[rfpc_pkg::CSC_MUX_SWAP]
    |=> main_subcarrier == ($past(receive_input_two) > $past(win)))
    else $error("main path not fed from input two when swapped");
  a_level_peak: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && !tx_start |=> rssi_main_reg >= $past(rssi_main_reg)
    && rssi_aux_reg >= $past(rssi_aux_reg))
    else $error("signal level peak dropped without transmission");
  a_proto_preset: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && wr_proto |=> tune_reg == rfpc_pkg::rfpc_preset($past(regs.wdata)))
    else $error("protocol write did not load presets");
  a_tune_write: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en && wr_tune |=> tune_reg == $past(regs.wdata)
    ##1 (!$past(clk_en) || band_sel == rfpc_pkg::rfpc_band_of($past(regs.wdata, 2))))
    else $error("tuning write not applied");
  a_band_select: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en |=> band_sel == rfpc_pkg::rfpc_band_of($past(tune_reg))
    && gain_cut_7db == (band_sel == rfpc_pkg::BAND_100_1500))
    else $error("passband select does not follow tuning bits");
  a_dig_window: assert property (@(posedge hclk) disable iff (!hresetn)
    clk_en |=> dig_gain_red == $past(tune_reg[rfpc_pkg::TUNE_GR_MSB:rfpc_pkg::TUNE_GR_LSB]))
    else $error("digitizer reduction does not follow field");

endmodule

// File: verif/rfpc_antenna_model.sv
// partner model: antenna dividers delivering a tag subcarrier on both inputs
`timescale 1ns/1ps
module rfpc_antenna_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       active,
  input  wire logic [7:0] amp_one,
  input  wire logic [7:0] amp_two,
  output logic      [7:0] rx_one,
  output logic      [7:0] rx_two
);
  logic [1:0] ph;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph <= 2'h0;
      rx_one <= 8'h00;
      rx_two <= 8'h00;
    end else begin
      ph <= ph + 2'h1;
      // subcarrier: two cycles at amplitude, two at ground; idle inputs sit at ground
      rx_one <= (active && ph[1]) ? amp_one : 8'h00;
      rx_two <= (active && ph[1]) ? amp_two : 8'h00;
    end
  end
endmodule

// File: verif/rf_receiver_path_control_tb_top.sv
// self-checking bench of the receiver path control block
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("[FAIL] %0t mismatch got %h exp %h", $time, (a), (e)); end end
module rf_receiver_path_control_tb_top;
  logic        hclk, hresetn, hsel, hwrite, rd_phase, active, tx_start, rx_sof;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, band_sel;
  logic [7:0]  amp_one, amp_two, rx_one, rx_two, rd_exp, exp_q[$];
  logic [23:0] lf;
  logic        hreadyout, hresp, main_subcarrier, mux_swap, gain_cut_7db, agc_frozen;
  logic [1:0]  dig_gain_red;
  logic [3:0]  agc_atten, a;
  int          fail_count, checks;
  wire         hready = hreadyout;

  rfpc_top #(.FREEZE_EDGES(4)) DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .receive_input_one(rx_one), .receive_input_two(rx_two),
    .tx_start(tx_start), .rx_sof(rx_sof), .main_subcarrier(main_subcarrier),
    .mux_swap(mux_swap), .band_sel(band_sel), .gain_cut_7db(gain_cut_7db),
    .dig_gain_red(dig_gain_red), .agc_atten(agc_atten), .agc_frozen(agc_frozen));
  rfpc_antenna_model ant (.hclk(hclk), .hresetn(hresetn), .active(active),
    .amp_one(amp_one), .amp_two(amp_two), .rx_one(rx_one), .rx_two(rx_two));

  function automatic logic [23:0] lfsr(input logic [23:0] x);
    return {x[22:0], x[23] ^ x[22] ^ x[21] ^ x[16]};
  endfunction

  // ****************************************************
  // bus master and read scoreboard
  // ****************************************************
  task automatic bus(input logic w, input logic [31:0] ad, input logic [7:0] d);
    @(posedge hclk);
    haddr <= ad;
    hwrite <= w;
    htrans <= 2'b10;
    if (!w) exp_q.push_back(d);
    do @(posedge hclk); while (hready !== 1'b1);
    lf = lfsr(lf);
    htrans <= 2'b00;
    hwdata <= {lf, d};
    rd_phase <= !w;
    do @(posedge hclk); while (hready !== 1'b1);
    rd_phase <= 1'b0;
  endtask
  task automatic pulse(input logic sof);
    @(posedge hclk);
    if (sof) rx_sof <= 1'b1;
    else tx_start <= 1'b1;
    @(posedge hclk);
    tx_start <= 1'b0;
    rx_sof <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge hclk);
  endtask
  always @(posedge hclk) begin
    if (rd_phase && hready === 1'b1) begin
      rd_exp = exp_q.pop_front();
      `CHK(hrdata, {24'h00_0000, rd_exp})
      `CHK(hresp, 1'b0)
    end
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    static logic [7:0] pre [4] = '{8'h40, 8'h20, 8'h00, 8'h80};
    static logic [2:0] bnd [4] = '{3'h2, 3'h3, 3'h0, 3'h1};
    static logic [7:0] tv [5] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h0C};
    static logic [2:0] tb [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
    {hresetn, hsel, hwrite, rd_phase, active, tx_start, rx_sof} = 7'h00;
    {haddr, hwdata, htrans, hsize, amp_one, amp_two} = '0;
    lf = 24'h00_0004;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    hsize <= 3'h2;
    settle(1);
    `CHK({mux_swap, band_sel, agc_atten}, 8'h00)
    bus(0, 32'h0000_0000, 8'h00);
    bus(0, 32'h0000_0028, 8'h00);
    bus(0, 32'h0000_003C, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      bus(1, 32'h0000_0004, 8'(i << 3));
      bus(0, 32'h0000_0028, pre[i]);
      settle(2);
      `CHK(band_sel, bnd[i])
    end
    for (int i = 0; i < 5; i++) begin
      bus(1, 32'h0000_0028, tv[i]);
      settle(2);
      `CHK(band_sel, tb[i])
      `CHK(gain_cut_7db, i == 3)
      `CHK(dig_gain_red, (i == 4) ? 2'b11 : 2'b00)
    end
    bus(0, 32'h0000_0028, 8'h0C);
    bus(1, 32'h0000_0008, 8'hFF);
    bus(0, 32'h0000_0008, 8'h00);
    $display("tuning test done");
    bus(1, 32'h0000_0028, 8'h00);
    amp_one <= 8'hE0;
    amp_two <= 8'h60;
    pulse(1'b0);
    active <= 1'b1;
    settle(12);
    bus(0, 32'h0000_003C, 8'h1F);
    bus(1, 32'h0000_0000, 8'h08);
    pulse(1'b0);
    settle(12);
    `CHK(mux_swap, 1'b1)
    bus(0, 32'h0000_003C, 8'h3B);
    a = 4'h0;
    repeat (8) begin
      settle(1);
      a = a | {3'h0, main_subcarrier};
    end
    `CHK(a, 4'h1)
    amp_two <= 8'h00;
    settle(3);
    repeat (10) begin
      settle(1);
      `CHK(main_subcarrier, 1'b0)
    end
    $display("routing test done");
    amp_one <= 8'hF0;
    bus(1, 32'h0000_0000, 8'h04);
    pulse(1'b1);
    settle(60);
    `CHK(agc_frozen, 1'b1)
    `CHK(agc_atten != 4'h0, 1'b1)
    a = agc_atten;
    settle(20);
    `CHK(agc_atten, a)
    bus(1, 32'h0000_0028, 8'h01);
    pulse(1'b1);
    settle(60);
    `CHK(agc_frozen, 1'b0)
    `CHK(agc_atten, 4'hF)
    amp_one <= 8'h40;
    pulse(1'b1);
    settle(30);
    `CHK(agc_atten, 4'h0)
    bus(1, 32'h0000_0028, 8'h03);
    settle(30);
    `CHK(agc_atten != 4'h0, 1'b1)
    bus(1, 32'h0000_0000, 8'h00);
    settle(30);
    `CHK({agc_atten, agc_frozen}, 5'h00)
    $display("gain control test done");
    tally_and_finish();
  end
endmodule
